// *** common/tcf_pkg.sv ***
/*
  constants for the paired timer configuration block: register addresses,
  field positions, reset values and clock divide counts.
  assumes an 8-bit special function register bus with 8-bit addresses.
*/
package tcf_pkg;

  // ***************************************************************
  // register addresses, index 0 is timer 4, index 1 is timer 5
  // ***************************************************************
  localparam logic [7:0] TCF_T4_CFG_ADDR = 8'hc9;
  localparam logic [7:0] TCF_T4_CAPL_ADDR = 8'hca;
  localparam logic [7:0] TCF_T4_CAPH_ADDR = 8'hcb;
  localparam logic [7:0] TCF_T4_CNTL_ADDR = 8'hcc;
  localparam logic [7:0] TCF_T4_CNTH_ADDR = 8'hcd;
  localparam logic [7:0] TCF_T5_CFG_ADDR = 8'h96;
  localparam logic [7:0] TCF_T5_CAPL_ADDR = 8'h92;
  localparam logic [7:0] TCF_T5_CAPH_ADDR = 8'h93;
  localparam logic [7:0] TCF_T5_CNTL_ADDR = 8'h94;
  localparam logic [7:0] TCF_T5_CNTH_ADDR = 8'h95;

  // ***************************************************************
  // configuration register fields and reset values
  // ***************************************************************
  localparam int TCF_CLK_SEL_LSB = 3;
  localparam int TCF_TOG_STATE_BIT = 2;
  localparam int TCF_TOG_OE_BIT = 1;
  localparam int TCF_DEC_EN_BIT = 0;
  localparam logic [7:0] TCF_CFG_RESET = 8'h00;
  localparam logic [15:0] TCF_CNT_RESET = 16'h0000;
  localparam logic [15:0] TCF_CNT_MAX = 16'hffff;

  // ***************************************************************
  // count clock selection and divide counts
  // ***************************************************************
  localparam logic [1:0] TCF_SEL_DIV12 = 2'b00;
  localparam logic [1:0] TCF_SEL_SYS = 2'b01;
  localparam logic [1:0] TCF_SEL_EXT8 = 2'b10;
  localparam logic [1:0] TCF_SEL_DIV2 = 2'b11;
  localparam int TCF_DIV_SLOW = 12;
  localparam int TCF_DIV_FAST = 2;
  localparam int TCF_DIV_EXT = 8;

endpackage : tcf_pkg

// *** common/tcf_tick_if.sv ***
/*
  carrier between a timer channel and its count clock prescaler.
  assumes both ends run on the one system clock.
*/
`timescale 1ns/100ps

interface tcf_tick_if;
  logic [1:0] count_clock_select;
  logic ext_clk;
  logic tick;

  modport ctl (output count_clock_select, output ext_clk, input tick);
  modport gen (input count_clock_select, input ext_clk, output tick);
endinterface : tcf_tick_if

// *** core/tcf_prescale.sv ***
/*
  count clock prescaler for one timer: system clock / 12, / 1, / 2 or
  external clock synchronised and divided by 8; emits one-cycle ticks.
  assumes the external clock is slower than half the system clock.
*/
`timescale 1ns/100ps

module tcf_prescale
  import tcf_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  tcf_tick_if.gen tk
);

  logic [3:0] div_cnt;
  logic [2:0] ext_cnt;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_rise;
  logic [3:0] div_last;

  // ***************************************************************
  // system clock divider
  // ***************************************************************
  always_comb begin
    div_last = 4'(TCF_DIV_FAST - 1);
    if (tk.count_clock_select == TCF_SEL_DIV12) begin
      div_last = 4'(TCF_DIV_SLOW - 1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt <= 4'h0;
    end else if (div_cnt >= div_last) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // ***************************************************************
  // external clock synchroniser and divide by 8
  // ***************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= tk.ext_clk;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_rise = ext_sync & ~ext_prev;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_cnt <= 3'h0;
    end else if (ext_rise) begin
      ext_cnt <= ext_cnt + 3'h1;
    end
  end

  // ***************************************************************
  // tick selection
  // ***************************************************************
  always_comb begin
    case (tk.count_clock_select)
      TCF_SEL_SYS: tk.tick = 1'b1;
      TCF_SEL_EXT8: tk.tick = ext_rise && (ext_cnt == 3'(TCF_DIV_EXT - 1));
      default: tk.tick = (div_cnt == div_last);
    endcase
  end

endmodule : tcf_prescale

// *** core/tcf_timer_pair.sv ***
/*
  two identical 16-bit timers with their configuration, capture/reload
  and count registers on the special function register bus.
  assumes run, mode and edge enable bits come from the control register
  logic outside; index 0 is timer 4 and index 1 is timer 5.
*/
// Notes on behaviour
// - select field 00 picks system clock /12, 01 undivided, 11 /2.
// - select 10 counts external clock divided by 8, synchronised first.
// - toggle enable set drives the toggle state onto the pin, else none.
// - decrement enable clear: count up only, external input level ignored.
// - decrement enable set: input low counts down, input high counts up.
// - direction follows the external input level, not its edges.
// - level direction only in auto-reload with edges enabled; else an edge reloads (auto-reload) or captures (capture mode).
// - auto-reload: pair holds reload value; capture mode: pair takes count.
// - timer counts only while run control is set.
`timescale 1ns/100ps

module tcf_timer_pair
  import tcf_pkg::*;
#(
  parameter int NUM_TIMERS = 2
)
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic [NUM_TIMERS-1:0] ext_clk_in,
  input wire logic [NUM_TIMERS-1:0] external_timer_input_in,
  input wire logic [NUM_TIMERS-1:0] run_control_in,
  input wire logic [NUM_TIMERS-1:0] counter_select_in,
  input wire logic [NUM_TIMERS-1:0] capture_reload_select_in,
  input wire logic [NUM_TIMERS-1:0] external_input_enable_in,
  input wire logic [NUM_TIMERS-1:0] external_event_flag_clear_in,
  output logic [NUM_TIMERS-1:0] external_event_flag_out,
  output logic [NUM_TIMERS-1:0] overflow_out,
  output logic [NUM_TIMERS-1:0] toggle_pin_out,
  output logic [NUM_TIMERS-1:0] toggle_pin_oe_out
);

  logic [7:0] rd_word [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] rd_hit;
  logic [7:0] next_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      // ***************************************************************
      // per timer register addresses
      // ***************************************************************
      localparam logic [7:0] A_CFG = (gi == 0) ? TCF_T4_CFG_ADDR : TCF_T5_CFG_ADDR;
      localparam logic [7:0] A_CAPL = (gi == 0) ? TCF_T4_CAPL_ADDR : TCF_T5_CAPL_ADDR;
      localparam logic [7:0] A_CAPH = (gi == 0) ? TCF_T4_CAPH_ADDR : TCF_T5_CAPH_ADDR;
      localparam logic [7:0] A_CNTL = (gi == 0) ? TCF_T4_CNTL_ADDR : TCF_T5_CNTL_ADDR;
      localparam logic [7:0] A_CNTH = (gi == 0) ? TCF_T4_CNTH_ADDR : TCF_T5_CNTH_ADDR;

      logic [1:0] count_clock_select;
      logic toggle_output_state;
      logic toggle_output_enable;
      logic decrement_enable;
      logic [15:0] capture_reload;
      logic [15:0] count;
      logic external_event_flag;
      logic ext_in_prev;
      logic ext_fall;
      logic step;
      logic count_down;
      logic auto_reload;
      logic wrap_up;
      logic wrap_down;
      logic edge_event;
      logic reload_event;
      logic wr_cfg;
      logic wr_capl;
      logic wr_caph;
      logic wr_cntl;
      logic wr_cnth;
      logic [15:0] next_count;

      tcf_tick_if tk ();

      assign tk.count_clock_select = count_clock_select;
      assign tk.ext_clk = ext_clk_in[gi];

      tcf_prescale u_prescale (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .tk(tk)
      );

      // ***************************************************************
      // register write decode
      // ***************************************************************
      assign wr_cfg = sfr_wr_in && (sfr_addr_in == A_CFG);
      assign wr_capl = sfr_wr_in && (sfr_addr_in == A_CAPL);
      assign wr_caph = sfr_wr_in && (sfr_addr_in == A_CAPH);
      assign wr_cntl = sfr_wr_in && (sfr_addr_in == A_CNTL);
      assign wr_cnth = sfr_wr_in && (sfr_addr_in == A_CNTH);

      // ***************************************************************
      // count events and direction
      // ***************************************************************
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ext_in_prev <= 1'b1;
        end else begin
          ext_in_prev <= external_timer_input_in[gi];
        end
      end

      assign ext_fall = ext_in_prev & ~external_timer_input_in[gi];
      assign auto_reload = ~capture_reload_select_in[gi];
      // counter function steps on input falling edges, timer function on ticks
      assign step = run_control_in[gi] && (counter_select_in[gi] ? ext_fall : tk.tick);
      assign count_down = decrement_enable && external_input_enable_in[gi] && auto_reload
                          && !external_timer_input_in[gi];
      assign wrap_up = step && !count_down && (count == TCF_CNT_MAX);
      assign wrap_down = step && count_down && (count == capture_reload);
      assign edge_event = external_input_enable_in[gi] && ext_fall
                          && (capture_reload_select_in[gi] || !decrement_enable);
      assign reload_event = auto_reload && (wrap_up || wrap_down || edge_event);

      always_comb begin
        next_count = count;
        if (auto_reload && edge_event) begin
          next_count = capture_reload;
        end else if (wrap_up) begin
          next_count = auto_reload ? capture_reload : TCF_CNT_RESET;
        end else if (wrap_down) begin
          next_count = TCF_CNT_MAX;
        end else if (step) begin
          next_count = count_down ? count - 16'h0001 : count + 16'h0001;
        end
      end

      // ***************************************************************
      // counter and capture/reload registers
      // ***************************************************************
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          count <= TCF_CNT_RESET;
        end else begin
          count <= next_count;
          if (wr_cntl) begin
            count[7:0] <= sfr_wdata_in;
          end
          if (wr_cnth) begin
            count[15:8] <= sfr_wdata_in;
          end
        end
      end

      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          capture_reload <= TCF_CNT_RESET;
        end else begin
          if (capture_reload_select_in[gi] && edge_event) begin
            capture_reload <= count;
          end
          if (wr_capl) begin
            capture_reload[7:0] <= sfr_wdata_in;
          end
          if (wr_caph) begin
            capture_reload[15:8] <= sfr_wdata_in;
          end
        end
      end

      // ***************************************************************
      // configuration register and toggle state
      // ***************************************************************
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          count_clock_select <= TCF_CFG_RESET[TCF_CLK_SEL_LSB +: 2];
          toggle_output_enable <= TCF_CFG_RESET[TCF_TOG_OE_BIT];
          decrement_enable <= TCF_CFG_RESET[TCF_DEC_EN_BIT];
        end else if (wr_cfg) begin
          count_clock_select <= sfr_wdata_in[TCF_CLK_SEL_LSB +: 2];
          toggle_output_enable <= sfr_wdata_in[TCF_TOG_OE_BIT];
          decrement_enable <= sfr_wdata_in[TCF_DEC_EN_BIT];
        end
      end

      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          toggle_output_state <= TCF_CFG_RESET[TCF_TOG_STATE_BIT];
        end else if (wr_cfg) begin
          toggle_output_state <= sfr_wdata_in[TCF_TOG_STATE_BIT];
        end else if (reload_event && !counter_select_in[gi] && toggle_output_enable) begin
          toggle_output_state <= ~toggle_output_state;
        end
      end

      // ***************************************************************
      // external event flag, set wins over clear
      // ***************************************************************
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          external_event_flag <= 1'b0;
        end else if (edge_event) begin
          external_event_flag <= 1'b1;
        end else if (external_event_flag_clear_in[gi]) begin
          external_event_flag <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          overflow_out[gi] <= 1'b0;
        end else begin
          overflow_out[gi] <= wrap_up || wrap_down;
        end
      end

      assign external_event_flag_out[gi] = external_event_flag;
      assign toggle_pin_out[gi] = toggle_output_enable & toggle_output_state;
      assign toggle_pin_oe_out[gi] = toggle_output_enable;

      // ***************************************************************
      // read mux for this timer
      // ***************************************************************
      always_comb begin
        rd_hit[gi] = 1'b1;
        rd_word[gi] = 8'h00;
        if (sfr_addr_in == A_CFG) begin
          rd_word[gi][TCF_CLK_SEL_LSB +: 2] = count_clock_select;
          rd_word[gi][TCF_TOG_STATE_BIT] = toggle_output_state;
          rd_word[gi][TCF_TOG_OE_BIT] = toggle_output_enable;
          rd_word[gi][TCF_DEC_EN_BIT] = decrement_enable;
        end else if (sfr_addr_in == A_CAPL) begin
          rd_word[gi] = capture_reload[7:0];
        end else if (sfr_addr_in == A_CAPH) begin
          rd_word[gi] = capture_reload[15:8];
        end else if (sfr_addr_in == A_CNTL) begin
          rd_word[gi] = count[7:0];
        end else if (sfr_addr_in == A_CNTH) begin
          rd_word[gi] = count[15:8];
        end else begin
          rd_hit[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // bus read data, unmapped addresses read zero
  // ***************************************************************
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (rd_hit[i]) begin
        next_rdata = rd_word[i];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= next_rdata;
    end
  end

endmodule : tcf_timer_pair

// *** tb/tcf_pair_chk.sv ***
/*
  assertions on the ports of the timer pair.
  assumes it is bound into tcf_timer_pair.
*/
`timescale 1ns/100ps

module tcf_pair_chk
  import tcf_pkg::*;
#(
  parameter int NUM_TIMERS = 2
)
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [NUM_TIMERS-1:0] ext_clk_in,
  input wire logic [NUM_TIMERS-1:0] external_timer_input_in,
  input wire logic [NUM_TIMERS-1:0] run_control_in,
  input wire logic [NUM_TIMERS-1:0] counter_select_in,
  input wire logic [NUM_TIMERS-1:0] capture_reload_select_in,
  input wire logic [NUM_TIMERS-1:0] external_input_enable_in,
  input wire logic [NUM_TIMERS-1:0] external_event_flag_clear_in,
  input wire logic [NUM_TIMERS-1:0] external_event_flag_out,
  input wire logic [NUM_TIMERS-1:0] overflow_out,
  input wire logic [NUM_TIMERS-1:0] toggle_pin_out,
  input wire logic [NUM_TIMERS-1:0] toggle_pin_oe_out
);
  // ***************************
  // shadow of timer 4 config
  // ***************************
  logic [7:0] cfg4;
  logic wr4;
  logic wr5;
  assign wr4 = sfr_wr_in && sfr_addr_in == TCF_T4_CFG_ADDR;
  assign wr5 = sfr_wr_in && sfr_addr_in == TCF_T5_CFG_ADDR;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg4 <= TCF_CFG_RESET;
    end else if (wr4) begin
      cfg4 <= sfr_wdata_in;
    end
  end
  // ***************************
  // assertions
  // ***************************
  default clocking dc @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  pin_gate_a: assert property ((toggle_pin_out & ~toggle_pin_oe_out) == '0)
    else $error("toggle pin driven while disabled");
  oe_set4_a: assert property (wr4 |=> toggle_pin_oe_out[0] == $past(sfr_wdata_in[1]))
    else $error("timer 4 pin enable wrong");
  oe_set5_a: assert property (wr5 |=> toggle_pin_oe_out[1] == $past(sfr_wdata_in[1]))
    else $error("timer 5 pin enable wrong");
  oe_hold_a: assert property (!wr4 && !wr5 |=> $stable(toggle_pin_oe_out))
    else $error("pin enable moved without write");
  cfg_read_a: assert property (sfr_rd_in && sfr_addr_in == TCF_T4_CFG_ADDR |=>
    {sfr_rdata_out[7:3], sfr_rdata_out[0]} == {3'h0, $past(cfg4[4:3]), $past(cfg4[0])})
    else $error("config read back wrong");
  stop_quiet_a: assert property (!run_control_in[0] [*2] |=> !overflow_out[0])
    else $error("overflow while stopped");
  flag_cause_a: assert property ($rose(external_event_flag_out[0]) |->
    $past(external_input_enable_in[0]) && !$past(external_timer_input_in[0]))
    else $error("flag set without input edge");
  flag_keep_a: assert property (external_event_flag_out[0] &&
    !external_event_flag_clear_in[0] |=> external_event_flag_out[0])
    else $error("flag lost without clear");
  flag_clear_a: assert property (external_event_flag_clear_in[0] &&
    !external_input_enable_in[0] |=> !external_event_flag_out[0])
    else $error("flag not cleared");
  sq_wave_a: assert property ($changed(toggle_pin_out[0]) && $stable(toggle_pin_oe_out[0])
    && !$past(sfr_wr_in) && !$past(external_input_enable_in[0]) |-> ##[0:1] overflow_out[0])
    else $error("toggle moved without reload");
  cover property (overflow_out[0]);
  cover property ($rose(external_event_flag_out[0]));
  cover property (wr5);
endmodule : tcf_pair_chk

bind tcf_timer_pair tcf_pair_chk #(.NUM_TIMERS(NUM_TIMERS)) chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out), .ext_clk_in(ext_clk_in),
  .external_timer_input_in(external_timer_input_in), .run_control_in(run_control_in),
  .counter_select_in(counter_select_in), .capture_reload_select_in(capture_reload_select_in),
  .external_input_enable_in(external_input_enable_in),
  .external_event_flag_clear_in(external_event_flag_clear_in),
  .external_event_flag_out(external_event_flag_out), .overflow_out(overflow_out),
  .toggle_pin_out(toggle_pin_out), .toggle_pin_oe_out(toggle_pin_oe_out)
);

// *** tb/test_tcf_timer_pair.sv ***
/*
  self-checking bench for the timer pair, driven over the register bus.
  assumes the package, design and checker are compiled first.
*/
`timescale 1ns/100ps

module test_tcf_timer_pair
  import tcf_pkg::*;
;
  logic ref_clk_in, rst_b_in, sfr_wr_in, sfr_rd_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [1:0] ext_clk_in, external_timer_input_in, run_control_in, counter_select_in;
  logic [1:0] capture_reload_select_in, external_input_enable_in, external_event_flag_clear_in;
  logic [1:0] external_event_flag_out, overflow_out, toggle_pin_out, toggle_pin_oe_out;
  logic [7:0] cfg_a [2] = '{TCF_T4_CFG_ADDR, TCF_T5_CFG_ADDR};
  logic [7:0] cnt_a [2] = '{TCF_T4_CNTL_ADDR, TCF_T5_CNTL_ADDR};
  int failures, num_checks, cycles;

  tcf_timer_pair uut (.*);

  initial begin
    ref_clk_in = 1'h0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      test_done();
    end
  end
  // ***************************
  // bus and compare tasks
  // ***************************
  task automatic test_done();
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] got);
    num_checks++;
    if (got !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask : chk8
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'h1;
    tick(1);
    sfr_wr_in = 1'h0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr_in = a;
    sfr_rd_in = 1'h1;
    tick(1);
    sfr_rd_in = 1'h0;
    chk8($sformatf("register %h", a), e, sfr_rdata_out);
    tick(1);
  endtask : rd
  task automatic set16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask : set16
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 8'h01, e[15:8]);
  endtask : rd16
  task automatic run_for(input int i, input int n);
    run_control_in[i] = 1'h1;
    tick(n);
    run_control_in[i] = 1'h0;
  endtask : run_for
  // ***************************
  // test sequence
  // ***************************
  initial begin
    failures = 0;
    num_checks = 0;
    cycles = 0;
    {rst_b_in, sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in} = '0;
    {ext_clk_in, run_control_in, counter_select_in, capture_reload_select_in} = '0;
    {external_input_enable_in, external_event_flag_clear_in} = '0;
    external_timer_input_in = 2'h3;
    tick(4);
    rst_b_in = 1'h1;
    rd(TCF_T4_CFG_ADDR, TCF_CFG_RESET);
    rd(TCF_T5_CFG_ADDR, TCF_CFG_RESET);
    rd(8'h97, 8'h00);
    wr(TCF_T4_CFG_ADDR, 8'hff);
    rd(TCF_T4_CFG_ADDR, 8'h1f);
    wr(TCF_T5_CFG_ADDR, 8'h04);
    chk8("toggle pin", 8'h01, {6'h00, toggle_pin_out});
    chk8("pin enable", 8'h01, {6'h00, toggle_pin_oe_out});
    for (int i = 0; i < 2; i++) begin
      for (int s = 0; s < 4; s++) begin
        if (s != 2) begin
          wr(cfg_a[i], {3'h0, s[1:0], 3'h0});
          set16(cnt_a[i], 16'h0000);
          run_for(i, 24);
          rd16(cnt_a[i], 16'(24 / (s == 0 ? TCF_DIV_SLOW : s == 1 ? 1 : TCF_DIV_FAST)));
        end
      end
    end
    tick(20);
    rd16(TCF_T5_CNTL_ADDR, 16'h000c);
    counter_select_in[1] = 1'h1;
    run_control_in[1] = 1'h1;
    repeat (3) begin
      external_timer_input_in[1] = 1'h0;
      tick(1);
      external_timer_input_in[1] = 1'h1;
      tick(1);
    end
    run_control_in[1] = 1'h0;
    counter_select_in[1] = 1'h0;
    rd16(TCF_T5_CNTL_ADDR, 16'h000f);
    wr(TCF_T4_CFG_ADDR, 8'h10);
    set16(TCF_T4_CNTL_ADDR, 16'h0000);
    run_control_in[0] = 1'h1;
    for (int k = 0; k < 32; k++) begin
      tick(2);
      ext_clk_in[0] = ~ext_clk_in[0];
    end
    tick(6);
    run_control_in[0] = 1'h0;
    rd16(TCF_T4_CNTL_ADDR, 16'(16 / TCF_DIV_EXT));
    wr(TCF_T4_CFG_ADDR, 8'h09);
    set16(TCF_T4_CAPL_ADDR, 16'h0000);
    set16(TCF_T4_CNTL_ADDR, 16'h0010);
    external_input_enable_in[0] = 1'h1;
    external_timer_input_in[0] = 1'h0;
    run_for(0, 4);
    rd16(TCF_T4_CNTL_ADDR, 16'h000c);
    run_for(0, 4);
    rd16(TCF_T4_CNTL_ADDR, 16'h0008);
    chk8("flag", 8'h00, {6'h00, external_event_flag_out});
    external_timer_input_in[0] = 1'h1;
    run_for(0, 4);
    rd16(TCF_T4_CNTL_ADDR, 16'h000c);
    external_timer_input_in[0] = 1'h0;
    tick(2);
    wr(TCF_T4_CFG_ADDR, 8'h08);
    run_for(0, 4);
    rd16(TCF_T4_CNTL_ADDR, 16'h0010);
    chk8("flag", 8'h00, {6'h00, external_event_flag_out});
    set16(TCF_T4_CAPL_ADDR, 16'h1234);
    external_timer_input_in[0] = 1'h1;
    tick(1);
    external_timer_input_in[0] = 1'h0;
    tick(2);
    rd16(TCF_T4_CNTL_ADDR, 16'h1234);
    chk8("flag", 8'h01, {6'h00, external_event_flag_out});
    external_event_flag_clear_in[0] = 1'h1;
    tick(1);
    external_event_flag_clear_in[0] = 1'h0;
    chk8("flag", 8'h00, {6'h00, external_event_flag_out});
    capture_reload_select_in[0] = 1'h1;
    set16(TCF_T4_CNTL_ADDR, 16'h0055);
    external_timer_input_in[0] = 1'h1;
    tick(1);
    external_timer_input_in[0] = 1'h0;
    tick(2);
    rd16(TCF_T4_CAPL_ADDR, 16'h0055);
    chk8("flag", 8'h01, {6'h00, external_event_flag_out});
    capture_reload_select_in[0] = 1'h0;
    external_input_enable_in[0] = 1'h0;
    external_event_flag_clear_in[0] = 1'h1;
    tick(1);
    external_event_flag_clear_in[0] = 1'h0;
    wr(TCF_T4_CFG_ADDR, 8'h0a);
    set16(TCF_T4_CAPL_ADDR, 16'hfffe);
    set16(TCF_T4_CNTL_ADDR, 16'hfffe);
    run_for(0, 2);
    chk8("overflow", 8'h01, {6'h00, overflow_out});
    chk8("toggle pin", 8'h01, {6'h00, toggle_pin_out});
    rd(TCF_T4_CFG_ADDR, 8'h0e);
    run_for(0, 2);
    chk8("toggle pin", 8'h00, {6'h00, toggle_pin_out});
    test_done();
  end
endmodule : test_tcf_timer_pair
